// ==== core/sfcs_ctrl.sv ====
/*
 command front end and status register of a serial flash device.
 assumes: serial clock only toggles while chip select is low (mode 0), resetn_i
 stands for a power cycle, array read data is held steady by the array.
*/
// Notes on behaviour
// (R01) status protect pattern (1,0) returns to (0,0) after a power cycle.
// (R02) quad enable 0 keeps pin functions; 1 turns them into data lines.
// (R03) three security locks default 0, once 1 stay 1; here a power cycle (resetn_i) clears them to 0.
// (R04) each security lock is set alone by status write; never cleared. Here a power cycle (resetn_i) resets it to 0.
// (R05) protect complement defaults 0 and joins block protect field.
// (R06) suspend sets erase or program paused flag depending on running operation.
// (R07) resume and power cycle clear both paused flags.
// (R08) scheme select picks complement/field or individual locks protection.
// (R09) all individual block locks are 1 after power-on and any reset.
// (R10) drive strength 00..11 gives 100, 75, 50 default, 25 percent.
// (R11) shared pin is pause when select 0, reset when 1, quad off only.
// (R12) with quad enable set the shared pin has no pause or reset.
// (R13) opcode shifts in msb first, sampled on rising serial clock.
// (R14) opcode byte first, then address, data, both or nothing.
// (R15) reads drive data after command; host may end after any bit.
// (R16) write-type commands need whole bytes at frame end or are rejected.
// (R17) partial program byte does nothing and keeps write latch set.
// (R18) 06H sets write latch; 05H, 35H, 15H return a status byte.
// (R19) 03H plus three address bytes streams data, no dummy.
// (R20) 0BH plus three address bytes and one dummy streams data.
// (R21) 02H address then data programs; 20H address only erases.
// (R22) software reset is 66H then 99H, each a lone opcode.
// (R23) write latch clear refuses status write, program and erase.
// (R24) busy flag is 1 throughout program, erase or status write.
// (R25) unknown opcodes are ignored until chip select rises.
// (R26) accepted status write clears write latch when it completes.
module sfcs_ctrl #(
	parameter int LOCK_BITS    = 16,
	parameter int PROG_CYCLES  = sfcs_pkg::T_PROG_NS / sfcs_pkg::CLK_PERIOD_NS,
	parameter int ERASE_CYCLES = sfcs_pkg::T_ERASE_NS / sfcs_pkg::CLK_PERIOD_NS,
	parameter int SWR_CYCLES   = sfcs_pkg::T_STAT_WR_NS / sfcs_pkg::CLK_PERIOD_NS
) (
	// system
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	// serial link
	input  wire logic                 sclk_i,
	input  wire logic                 cs_n_i,
	input  wire logic                 si_i,
	output logic                      so_o,
	output logic                      so_oe_o,
	// shared pins
	input  wire logic                 wp_n_i,
	input  wire logic                 hold_rst_n_i,
	// array side
	input  wire logic [7:0]           array_rdata_i,
	output logic      [23:0]          array_addr_o,
	// control outputs
	output logic                      busy_o,
	output logic                      quad_pins_o,
	output logic                      hold_paused_o,
	output logic      [1:0]           drive_strength_o,
	output logic                      prot_scheme_o,
	output logic      [5:0]           protect_field_o,
	output logic      [LOCK_BITS-1:0] block_locks_o
);

	localparam int CW = $clog2(ERASE_CYCLES + 1);

	typedef struct packed {
		logic [1:0]           cs_sync;
		logic                 cs_prev;
		logic [1:0]           tog_sync;
		logic                 tog_seen;
		logic [1:0]           wp_sync;
		logic [1:0]           hold_sync;
		sfcs_pkg::sfcs_status_t st;
		sfcs_pkg::sfcs_fsm_t  fsm;
		sfcs_pkg::sfcs_opk_t  opk;
		logic [CW-1:0]        cnt;
		logic                 rst_armed;
		logic                 quad_q;
		logic                 hold_q;
		logic [1:0]           drv_q;
		logic [LOCK_BITS-1:0] locks;
	} sfcs_core_t;

	typedef struct packed {
		logic                 tog;
		logic [6:0]           shift;
		sfcs_pkg::sfcs_frame_t fr;
		logic [23:0]          addr;
		logic [23:0]          st_sync1;
		logic [23:0]          st_sync2;
		logic [7:0]           rd_sync1;
		logic [7:0]           rd_sync2;
	} sfcs_link_t;

	sfcs_core_t s, n;
	sfcs_link_t l, m;
	logic       armed_q;
	logic       armed_rst_n;
	logic [2:0] bc, yc;
	logic [7:0] byte_in;
	logic [7:0] out_byte;
	logic       out_en;
	logic       frame_end, whole, one_byte, soft_cmd, pin_rst, stat_locked;

	function automatic logic [CW-1:0] op_cycles(sfcs_pkg::sfcs_opk_t k);
		case (k)
			sfcs_pkg::OPK_PROG:  return CW'(PROG_CYCLES - 1);
			sfcs_pkg::OPK_ERASE: return CW'(ERASE_CYCLES - 1);
			default:             return CW'(SWR_CYCLES - 1);
		endcase
	endfunction

	// link domain: shift in on rising serial clock
	assign armed_rst_n = resetn_i & ~cs_n_i;

	always_ff @(posedge sclk_i or negedge armed_rst_n) begin
		if (!armed_rst_n) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	always_comb begin
		m = l;
		byte_in = {l.shift, si_i};
		bc = armed_q ? l.fr.bit_cnt : sfcs_pkg::BIT_ZERO;
		yc = armed_q ? l.fr.byte_cnt : sfcs_pkg::BIT_ZERO;
		// a new frame flips the toggle so the core knows there is fresh content
		if (!armed_q) begin
			m.tog = ~l.tog;
		end
		m.st_sync1 = sfcs_pkg::sfcs_pack(s.st);
		m.st_sync2 = l.st_sync1;
		m.rd_sync1 = array_rdata_i;
		m.rd_sync2 = l.rd_sync1;
		m.shift = {l.shift[5:0], si_i};                                   // [R13]
		m.fr.bit_cnt = bc + 3'h1;
		m.fr.byte_cnt = yc;
		if (bc == sfcs_pkg::BIT_LAST) begin
			if (yc != sfcs_pkg::BYTES_SAT) begin
				m.fr.byte_cnt = yc + 3'h1;
			end
			if (yc == sfcs_pkg::BIT_ZERO) begin
				m.fr.opcode = byte_in;                                    // [R14]
			end
			if (yc == sfcs_pkg::BYTES_OPCODE) begin
				m.fr.data0 = byte_in;
			end
			if (yc >= sfcs_pkg::BYTES_OPCODE && yc < sfcs_pkg::BYTES_ADDR_END) begin
				m.addr = {l.addr[15:0], byte_in};                         // [R19] [R21]
			end
		end
	end

	always_ff @(posedge sclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			l <= '0;
		end else begin
			l <= m;
		end
	end

	// data-out phase; opcode is only trusted once this frame has a full byte
	always_comb begin
		out_byte = 8'h00;
		out_en = 1'b0;
		if (armed_q && l.fr.byte_cnt >= sfcs_pkg::BYTES_OPCODE) begin
			case (l.fr.opcode)
				sfcs_pkg::OP_STAT_RD1: begin
					out_byte = l.st_sync2[7:0];                           // [R18]
					out_en = 1'b1;
				end
				sfcs_pkg::OP_STAT_RD2: begin
					out_byte = l.st_sync2[15:8];
					out_en = 1'b1;
				end
				sfcs_pkg::OP_STAT_RD3: begin
					out_byte = l.st_sync2[23:16];
					out_en = 1'b1;
				end
				sfcs_pkg::OP_READ: begin
					out_byte = l.rd_sync2;                                // [R19]
					out_en = l.fr.byte_cnt >= sfcs_pkg::BYTES_ADDR_END;
				end
				sfcs_pkg::OP_FAST_READ: begin
					out_byte = l.rd_sync2;                                // [R20]
					out_en = l.fr.byte_cnt >= sfcs_pkg::BYTES_FAST_RD;
				end
				default: begin
					out_en = 1'b0;
				end
			endcase
		end
	end

	// chip select high ends the output at once, whatever bit it was on
	always_ff @(negedge sclk_i or negedge armed_rst_n) begin
		if (!armed_rst_n) begin
			so_o <= 1'b0;                                                 // [R15]
			so_oe_o <= 1'b0;
		end else begin
			so_o <= out_byte[~l.fr.bit_cnt];
			so_oe_o <= out_en;
		end
	end

	// core domain; frame content is read only after chip select has risen and
	// the serial clock is still, so it is steady across the crossing
	assign frame_end = s.cs_sync[1] & ~s.cs_prev & (s.tog_sync[1] != s.tog_seen);
	assign whole = l.fr.bit_cnt == sfcs_pkg::BIT_ZERO;
	assign one_byte = whole & (l.fr.byte_cnt == sfcs_pkg::BYTES_OPCODE);
	assign soft_cmd = frame_end & s.rst_armed & one_byte & (l.fr.opcode == sfcs_pkg::OP_RST_DO);
	assign pin_rst = ~s.st.quad_io_enable & s.st.hold_or_reset_select & ~s.hold_sync[1];
	// hardware protect reads the pin only while it is not a data line
	assign stat_locked = s.st.status_protect_hi |
		(s.st.status_protect_lo & ~s.st.quad_io_enable & ~s.wp_sync[1]);

	always_comb begin
		n = s;
		n.cs_sync = {s.cs_sync[0], cs_n_i};
		n.cs_prev = s.cs_sync[1];
		n.tog_sync = {s.tog_sync[0], l.tog};
		n.wp_sync = {s.wp_sync[0], wp_n_i};
		n.hold_sync = {s.hold_sync[0], hold_rst_n_i};
		if (s.fsm == sfcs_pkg::ST_BUSY) begin
			if (s.cnt == '0) begin
				n.fsm = sfcs_pkg::ST_IDLE;
				n.st.busy_flag = 1'b0;                                    // [R24]
				n.st.write_latch = 1'b0;                                  // [R26]
			end else begin
				n.cnt = s.cnt - CW'(1);
			end
		end
		if (frame_end) begin
			n.tog_seen = s.tog_sync[1];
			n.rst_armed = one_byte & (l.fr.opcode == sfcs_pkg::OP_RST_ENABLE); // [R22]
			case (s.fsm)
				sfcs_pkg::ST_IDLE: begin
					case (l.fr.opcode)
						sfcs_pkg::OP_WLATCH_SET: begin
							if (one_byte) begin
								n.st.write_latch = 1'b1;                  // [R18] [R16]
							end
						end
						sfcs_pkg::OP_WLATCH_CLR: begin
							if (one_byte) begin
								n.st.write_latch = 1'b0;                  // [R16]
							end
						end
						sfcs_pkg::OP_STAT_WR1, sfcs_pkg::OP_STAT_WR2, sfcs_pkg::OP_STAT_WR3: begin
							if (whole && l.fr.byte_cnt == sfcs_pkg::BYTES_STAT_WR &&
								s.st.write_latch && !stat_locked) begin   // [R16] [R23]
								n.fsm = sfcs_pkg::ST_BUSY;
								n.opk = sfcs_pkg::OPK_SWR;
								n.cnt = op_cycles(sfcs_pkg::OPK_SWR);
								n.st.busy_flag = 1'b1;                    // [R24]
								if (l.fr.opcode == sfcs_pkg::OP_STAT_WR1) begin
									n.st.status_protect_lo = l.fr.data0[sfcs_pkg::W1_SP_LO];
									n.st.block_protect_field =
										l.fr.data0[sfcs_pkg::W1_BP_HI:sfcs_pkg::W1_BP_LO];
								end else if (l.fr.opcode == sfcs_pkg::OP_STAT_WR2) begin
									n.st.protect_complement = l.fr.data0[sfcs_pkg::W2_CMP]; // [R05]
									n.st.security_lock = s.st.security_lock |
										l.fr.data0[sfcs_pkg::W2_LOCK_HI:sfcs_pkg::W2_LOCK_LO]; // [R03] [R04]
									n.st.quad_io_enable = l.fr.data0[sfcs_pkg::W2_QUAD];
									n.st.status_protect_hi = l.fr.data0[sfcs_pkg::W2_SP_HI];
								end else begin
									n.st.hold_or_reset_select = l.fr.data0[sfcs_pkg::W3_HRSEL];
									n.st.drive_strength =
										l.fr.data0[sfcs_pkg::W3_DRV_HI:sfcs_pkg::W3_DRV_LO];
									n.st.protect_scheme_select = l.fr.data0[sfcs_pkg::W3_WPS];
								end
							end
						end
						sfcs_pkg::OP_PAGE_PROG: begin
							// a trailing partial byte leaves everything, latch included
							if (whole && l.fr.byte_cnt >= sfcs_pkg::BYTES_PROG_MIN &&
								s.st.write_latch) begin                   // [R17] [R21] [R23]
								n.fsm = sfcs_pkg::ST_BUSY;
								n.opk = sfcs_pkg::OPK_PROG;
								n.cnt = op_cycles(sfcs_pkg::OPK_PROG);
								n.st.busy_flag = 1'b1;
							end
						end
						sfcs_pkg::OP_SECT_ERASE: begin
							if (whole && l.fr.byte_cnt == sfcs_pkg::BYTES_ADDR_END &&
								s.st.write_latch) begin                   // [R21] [R23]
								n.fsm = sfcs_pkg::ST_BUSY;
								n.opk = sfcs_pkg::OPK_ERASE;
								n.cnt = op_cycles(sfcs_pkg::OPK_ERASE);
								n.st.busy_flag = 1'b1;
							end
						end
						default: begin
							n.fsm = s.fsm;                                // [R25]
						end
					endcase
				end
				sfcs_pkg::ST_BUSY: begin
					// a status write cannot be paused
					if (one_byte && l.fr.opcode == sfcs_pkg::OP_SUSPEND &&
						s.opk != sfcs_pkg::OPK_SWR && s.cnt != '0) begin
						n.fsm = sfcs_pkg::ST_SUSP;
						n.st.busy_flag = 1'b0;
						n.st.erase_paused_flag = s.opk == sfcs_pkg::OPK_ERASE;  // [R06]
						n.st.program_paused_flag = s.opk == sfcs_pkg::OPK_PROG;
					end
				end
				sfcs_pkg::ST_SUSP: begin
					if (one_byte && l.fr.opcode == sfcs_pkg::OP_RESUME) begin
						n.fsm = sfcs_pkg::ST_BUSY;
						n.st.busy_flag = 1'b1;
						n.st.erase_paused_flag = 1'b0;                    // [R07]
						n.st.program_paused_flag = 1'b0;
					end
				end
				default: begin
					n.fsm = sfcs_pkg::ST_IDLE;
				end
			endcase
		end
		// software or pin reset: volatile state only, non-volatile bits survive
		if (soft_cmd || pin_rst) begin                                    // [R11] [R22]
			n.fsm = sfcs_pkg::ST_IDLE;
			n.rst_armed = 1'b0;
			n.st.busy_flag = 1'b0;
			n.st.write_latch = 1'b0;
			n.st.erase_paused_flag = 1'b0;
			n.st.program_paused_flag = 1'b0;
			n.locks = '1;                                                 // [R09]
		end
		n.quad_q = s.st.quad_io_enable;                                   // [R02]
		n.hold_q = ~s.st.quad_io_enable & ~s.st.hold_or_reset_select & ~s.hold_sync[1]; // [R12]
		n.drv_q = s.st.drive_strength;                                    // [R10]
	end

	// power cycle: non-volatile bits return to defaults, protect pattern clears
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '{st: sfcs_pkg::ST_RESET, fsm: sfcs_pkg::ST_IDLE, opk: sfcs_pkg::OPK_PROG,
				cs_sync: 2'h3, cs_prev: 1'b1, wp_sync: 2'h3, hold_sync: 2'h3,
				drv_q: sfcs_pkg::DRV_50, locks: '1, default: '0};     // [R01] [R09]
		end else begin
			s <= n;
		end
	end

	assign busy_o = s.st.busy_flag;
	assign quad_pins_o = s.quad_q;
	assign hold_paused_o = s.hold_q;
	assign drive_strength_o = s.drv_q;
	assign prot_scheme_o = s.st.protect_scheme_select;                    // [R08]
	assign protect_field_o = {s.st.protect_complement, s.st.block_protect_field}; // [R05]
	assign block_locks_o = s.locks;
	assign array_addr_o = l.addr;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence seq_frame(logic [7:0] op);
		frame_end && one_byte && l.fr.opcode == op && !pin_rst;
	endsequence

	a_quad_pins_off: assert property (s.st.quad_io_enable |=> quad_pins_o && !hold_paused_o) // [R12]
		else $error("quad mode left a pin function on");
	a_lock_sticky: assert property ((~s.st.security_lock & $past(s.st.security_lock)) == 3'h0) // [R04]
		else $error("security lock bit cleared");
	a_susp_erase: assert property (seq_frame(sfcs_pkg::OP_SUSPEND) and
		s.fsm == sfcs_pkg::ST_BUSY && s.opk == sfcs_pkg::OPK_ERASE && s.cnt != '0
		|=> s.st.erase_paused_flag && !s.st.busy_flag)                   // [R06]
		else $error("erase suspend did not set its flag");
	a_resume_clear: assert property (seq_frame(sfcs_pkg::OP_RESUME) and s.fsm == sfcs_pkg::ST_SUSP
		|=> !s.st.erase_paused_flag && !s.st.program_paused_flag && s.st.busy_flag) // [R07]
		else $error("resume left a paused flag");
	a_no_latch_refuse: assert property (frame_end && !s.st.write_latch && s.fsm == sfcs_pkg::ST_IDLE
		|=> !s.st.busy_flag)                                              // [R23]
		else $error("write accepted without write latch");
	a_partial_keep: assert property (frame_end && !whole && s.fsm == sfcs_pkg::ST_IDLE && !pin_rst
		|=> !s.st.busy_flag && s.st.write_latch == $past(s.st.write_latch)) // [R16] [R17]
		else $error("partial byte frame had an effect");
	a_busy_done: assert property ($fell(s.st.busy_flag) && $past(s.fsm) == sfcs_pkg::ST_BUSY
		&& $past(s.cnt) == '0 |-> !s.st.write_latch)                     // [R26]
		else $error("write latch survived completion");
	a_busy_hold: assert property ($rose(s.st.busy_flag) && s.fsm == sfcs_pkg::ST_BUSY
		|-> s.st.busy_flag [*2])                                          // [R24]
		else $error("busy dropped right after start");
	a_locks_reset: assert property (soft_cmd || pin_rst |=> &s.locks)   // [R09]
		else $error("block locks not all set after reset");
	a_drv_follow: assert property (##1 drive_strength_o == $past(s.st.drive_strength)) // [R10]
		else $error("drive strength output out of step");

endmodule

// ==== core/sfcs_pkg.sv ====
/*
 serial flash command front end: shared opcodes, status layout, field positions,
 byte counts and timing constants.
 assumes a 10 MHz system clock and a host that stops the serial clock outside frames.
*/
package sfcs_pkg;

	// opcodes
	localparam logic [7:0] OP_WLATCH_SET = 8'h06;
	localparam logic [7:0] OP_WLATCH_CLR = 8'h04;
	localparam logic [7:0] OP_STAT_RD1   = 8'h05;
	localparam logic [7:0] OP_STAT_RD2   = 8'h35;
	localparam logic [7:0] OP_STAT_RD3   = 8'h15;
	localparam logic [7:0] OP_STAT_WR1   = 8'h01;
	localparam logic [7:0] OP_STAT_WR2   = 8'h31;
	localparam logic [7:0] OP_STAT_WR3   = 8'h11;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FAST_READ  = 8'h0B;
	localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_SUSPEND    = 8'h75;
	localparam logic [7:0] OP_RESUME     = 8'h7A;
	localparam logic [7:0] OP_RST_ENABLE = 8'h66;
	localparam logic [7:0] OP_RST_DO     = 8'h99;

	// frame byte counts (opcode included) and bit counts
	localparam logic [2:0] BYTES_OPCODE   = 3'h1;
	localparam logic [2:0] BYTES_STAT_WR  = 3'h2;
	localparam logic [2:0] BYTES_ADDR_END = 3'h4;
	localparam logic [2:0] BYTES_FAST_RD  = 3'h5;
	localparam logic [2:0] BYTES_PROG_MIN = 3'h5;
	localparam logic [2:0] BYTES_SAT      = 3'h7;
	localparam logic [2:0] BIT_LAST       = 3'h7;
	localparam logic [2:0] BIT_ZERO       = 3'h0;

	// data-byte field positions of the three status writes
	localparam int W1_SP_LO   = 7;
	localparam int W1_BP_HI   = 6;
	localparam int W1_BP_LO   = 2;
	localparam int W2_CMP     = 6;
	localparam int W2_LOCK_HI = 5;
	localparam int W2_LOCK_LO = 3;
	localparam int W2_QUAD    = 1;
	localparam int W2_SP_HI   = 0;
	localparam int W3_HRSEL   = 7;
	localparam int W3_DRV_HI  = 6;
	localparam int W3_DRV_LO  = 5;
	localparam int W3_WPS     = 2;

	// drive strength codes
	localparam logic [1:0] DRV_100 = 2'h0;
	localparam logic [1:0] DRV_75  = 2'h1;
	localparam logic [1:0] DRV_50  = 2'h2;
	localparam logic [1:0] DRV_25  = 2'h3;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_PROG_NS     = 600000;
	localparam int T_ERASE_NS    = 50000000;
	localparam int T_STAT_WR_NS  = 5000000;

	typedef struct packed {
		logic       hold_or_reset_select;
		logic [1:0] drive_strength;
		logic       protect_scheme_select;
		logic       erase_paused_flag;
		logic       protect_complement;
		logic [2:0] security_lock;
		logic       program_paused_flag;
		logic       quad_io_enable;
		logic       status_protect_hi;
		logic       status_protect_lo;
		logic [4:0] block_protect_field;
		logic       write_latch;
		logic       busy_flag;
	} sfcs_status_t;

	localparam sfcs_status_t ST_RESET = '{drive_strength: DRV_50, default: '0};

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] data0;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
	} sfcs_frame_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_SUSP = 3'b100
	} sfcs_fsm_t;

	typedef enum logic [2:0] {
		OPK_PROG  = 3'b001,
		OPK_ERASE = 3'b010,
		OPK_SWR   = 3'b100
	} sfcs_opk_t;

	// reserved bits S20, S19, S17, S16 read as zero
	function automatic logic [23:0] sfcs_pack(sfcs_status_t t);
		return {t.hold_or_reset_select, t.drive_strength, 2'h0, t.protect_scheme_select, 2'h0,
			t.erase_paused_flag, t.protect_complement, t.security_lock,
			t.program_paused_flag, t.quad_io_enable, t.status_protect_hi,
			t.status_protect_lo, t.block_protect_field, t.write_latch, t.busy_flag};
	endfunction

endpackage

// ==== verif/serial_flash_command_status_ctrl_tb_top.sv ====
/*
 testbench of the flash command front end: scenarios through the host model.
 assumes shortened busy counts; reset stands for a power cycle.
*/
module serial_flash_command_status_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_i = 1'b0;
	logic        resetn_i, sclk, cs_n, si, so, wp_n, hold_n, busy, quad, paused;
	logic        so_oe, pscheme;
	logic [5:0]  pfield;
	logic [7:0]  rdata;
	logic [1:0]  drv;
	logic [23:0] addr;
	logic [15:0] locks;
	int          num_errors = 0;
	int          n_tests = 0;

	always #50 clk_i = ~clk_i;

	sfcs_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));

	sfcs_ctrl #(.LOCK_BITS(16), .PROG_CYCLES(20), .ERASE_CYCLES(40), .SWR_CYCLES(10)) dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
		.so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n), .hold_rst_n_i(hold_n),
		.array_rdata_i(rdata), .array_addr_o(addr), .busy_o(busy), .quad_pins_o(quad),
		.hold_paused_o(paused), .drive_strength_o(drv), .prot_scheme_o(pscheme),
		.protect_field_o(pfield), .block_locks_o(locks));

	task automatic report_and_stop;
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmd(input logic [63:0] d, input int n);
		logic [7:0] r;
		host.frame(d, n, 0, r);
		// later checks then sample settled outputs
		@(negedge clk_i);
	endtask

	// read one status byte and compare
	task automatic sr(input logic [7:0] op, input logic [7:0] e);
		logic [7:0] v;
		host.frame({56'h0, op}, 8, 8, v);
		chk("status byte", {16'h0, e}, {16'h0, v});
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 200 && busy !== 1'b0; i++)
			@(negedge clk_i);
		chk("busy_o idle", 24'h0, {23'h0, busy});
	endtask

	task automatic wsr(input logic [7:0] op, input logic [7:0] v);
		cmd(64'h06, 8);
		cmd({48'h0, op, v}, 16);
		wait_idle();
	endtask

	task automatic t_defaults;
		sr(8'h05, 8'h00);
		sr(8'h35, 8'h00);
		sr(8'h15, 8'h40);
		chk("drive_strength_o", 24'h2, {22'h0, drv});
		chk("block_locks_o", 24'hFFFF, {8'h0, locks});
	endtask

	task automatic t_latch;
		cmd(64'h06, 7);
		sr(8'h05, 8'h00);
		cmd(64'h3108, 16);
		sr(8'h35, 8'h00);
		cmd(64'h06, 8);
		sr(8'h05, 8'h02);
		cmd({23'h0, 8'h02, 24'h000010, 8'h5A, 1'b1}, 41);
		sr(8'h05, 8'h02);
		cmd({24'h0, 8'h02, 24'h000010, 8'h5A}, 40);
		chk("busy_o program", 24'h1, {23'h0, busy});
		wait_idle();
		sr(8'h05, 8'h00);
	endtask

	task automatic t_locks;
		wsr(8'h31, 8'h08);
		sr(8'h35, 8'h08);
		sr(8'h05, 8'h00);
		wsr(8'h31, 8'h00);
		sr(8'h35, 8'h08);
		for (int c = 0; c < 4; c++) begin
			wsr(8'h11, 8'(c << 5));
			chk("drive_strength_o", 24'(c), {22'h0, drv});
		end
	endtask

	task automatic t_suspend;
		cmd(64'h06, 8);
		cmd({32'h0, 8'h20, 24'h001000}, 32);
		chk("busy_o erase", 24'h1, {23'h0, busy});
		cmd(64'h75, 8);
		sr(8'h35, 8'h88);
		cmd(64'h7A, 8);
		sr(8'h35, 8'h08);
		wait_idle();
		cmd(64'h06, 8);
		cmd({24'h0, 8'h02, 24'h000020, 8'hC3}, 40);
		cmd(64'h75, 8);
		sr(8'h35, 8'h0C);
		cmd(64'h7A, 8);
		sr(8'h35, 8'h08);
		wait_idle();
	endtask

	task automatic t_reads;
		logic [7:0] v;
		@(negedge clk_i) rdata = 8'hA5;
		host.frame({32'h0, 8'h03, 24'h123456}, 32, 8, v);
		chk("read data", 24'hA5, {16'h0, v});
		chk("array_addr_o", 24'h123456, addr);
		@(negedge clk_i) rdata = 8'h3C;
		host.frame({24'h0, 8'h0B, 24'h00ABCD, 8'h00}, 40, 8, v);
		chk("fast read data", 24'h3C, {16'h0, v});
		cmd(64'h06, 8);
		cmd(64'hFF, 8);
		sr(8'h05, 8'h02);
		cmd(64'h66, 8);
		cmd(64'h99, 8);
		sr(8'h05, 8'h00);
		chk("block_locks_o", 24'hFFFF, {8'h0, locks});
	endtask

	task automatic t_pins;
		@(negedge clk_i) hold_n = 1'b0;
		repeat (5) @(negedge clk_i);
		chk("hold_paused_o", 24'h1, {23'h0, paused});
		hold_n = 1'b1;
		wsr(8'h11, 8'h80);
		cmd(64'h06, 8);
		@(negedge clk_i) hold_n = 1'b0;
		repeat (5) @(negedge clk_i);
		chk("hold_paused_o reset", 24'h0, {23'h0, paused});
		hold_n = 1'b1;
		sr(8'h05, 8'h00);
		wsr(8'h01, 8'h80);
		@(negedge clk_i) wp_n = 1'b0;
		cmd(64'h06, 8);
		cmd(64'h0100, 16);
		sr(8'h05, 8'h82);
		@(negedge clk_i) wp_n = 1'b1;
		wsr(8'h01, 8'h7C);
		wsr(8'h31, 8'h4A);
		chk("quad_pins_o", 24'h1, {23'h0, quad});
		chk("protect_field_o", 24'h3F, {18'h0, pfield});
		cmd(64'h06, 8);
		@(negedge clk_i) hold_n = 1'b0;
		repeat (5) @(negedge clk_i);
		chk("hold_paused_o quad", 24'h0, {23'h0, paused});
		hold_n = 1'b1;
		sr(8'h05, 8'h7E);
		wsr(8'h11, 8'h04);
		chk("prot_scheme_o", 24'h1, {23'h0, pscheme});
		wsr(8'h31, 8'h0B);
		sr(8'h35, 8'h0B);
		@(negedge clk_i) resetn_i = 1'b0;
		repeat (8) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		sr(8'h35, 8'h00);
	endtask

	initial begin
		resetn_i = 1'b0;
		wp_n = 1'b1;
		hold_n = 1'b1;
		rdata = 8'h00;
		repeat (8) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		t_defaults();
		t_latch();
		t_locks();
		t_suspend();
		t_reads();
		t_pins();
		report_and_stop();
	end

	// whole run needs well under 1 ms
	initial begin
		#3000000;
		num_errors++;
		report_and_stop();
	end
endmodule

// ==== verif/sfcs_host_model.sv ====
/*
 host serial controller model: frames commands mode 0, shifts read bytes back.
 assumes the device shifts out on the falling serial clock.
*/
module sfcs_host_model (
	// serial link
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      si_o,
	input  wire logic so_i,
	input  wire logic so_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o   = 1'b0;
	end

	// n bits of d out msb first, then nr bits in; clock stands low outside frames
	task automatic frame(input logic [63:0] d, input int n, input int nr, output logic [7:0] r);
		r = 8'h00;
		#3 cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si_o = d[i];
			#7.5 sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
		end
		for (int i = 0; i < nr; i++) begin
			si_o = ~si_o;
			#7.5 sclk_o = 1'b1;
			// a bit only counts while the device enables its output
			r = {r[6:0], so_i & so_oe_i};
			#7.5 sclk_o = 1'b0;
		end
		#7.5 cs_n_o = 1'b1;
		si_o = ~si_o;
		#600;
	endtask
endmodule
